/* common/sems_pkg.sv */
// Shared constants, types and helpers of the serial EEPROM master sequencer
package sems_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int BUS_RATE_HZ = 100_000;
  localparam int QUARTER_CYCLES = CLK_HZ / (4 * BUS_RATE_HZ);
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMO_W = 21;
  localparam int QTR_W = 8;
  localparam int MW_ADDR_MAX = 11;
  localparam int MW_HEAD_BITS = 3;
  localparam int MW_DATA_BITS = 8;
  localparam int MW_FRAME_W = MW_HEAD_BITS + MW_ADDR_MAX + MW_DATA_BITS;
  localparam int BYTE_BITS = 8;

  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_MISC = 2'h0;
  localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] SUB_PROGRAM_DISABLE_CMD = 2'h0;
  localparam logic [1:0] SUB_PROGRAM_ENABLE_CMD = 2'h3;
  localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] STRAP_RESERVED = 2'h3;
  localparam logic [3:0] AW_SMALL = 4'h7;
  localparam logic [3:0] AW_MID = 4'h9;
  localparam logic [3:0] AW_LARGE = 4'hb;
  localparam logic SYNC_RST_LEVEL = 1'b1;
  localparam int SYNC_LAT_CYCLES = 5; // Pin change to synchroniser output, with margin

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_ERASE = 3'h2,
    CMD_ERASE_ALL_CMD = 3'h3,
    CMD_PROGRAM_DISABLE_CMD = 3'h4,
    CMD_PROGRAM_ENABLE_CMD = 3'h5,
    CMD_WRITE_ALL_CMD = 3'h6,
    CMD_LOAD = 3'h7
  } sems_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_I_START = 3'h1,
    ST_I_BYTE = 3'h2,
    ST_I_STOP = 3'h3,
    ST_M_SHIFT = 3'h4,
    ST_M_GAP = 3'h5,
    ST_M_STATUS = 3'h6,
    ST_FINISH = 3'h7
  } sems_state_e;

  typedef enum logic [2:0] {
    STEP_CTRL_W = 3'h0,
    STEP_ADDR_HI = 3'h1,
    STEP_ADDR_LO = 3'h2,
    STEP_CTRL_R = 3'h3,
    STEP_DATA = 3'h4,
    STEP_POLL = 3'h5,
    STEP_FIN = 3'h6,
    STEP_RX = 3'h7
  } sems_step_e;

  typedef struct packed {
    sems_state_e state;
    sems_step_e step;
    sems_cmd_e cmd;
    logic two_byte;
    logic [3:0] aw;
    logic [1:0] q;
    logic [QTR_W-1:0] tick;
    logic [TMO_W-1:0] hold;
    logic [TMO_W-1:0] tmo;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] remain;
    logic [4:0] mw_left;
    logic [MW_FRAME_W-1:0] frame;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic flag;
    logic rvalid;
    logic [7:0] rdata;
    logic od_level;
    logic scl_oe;
    logic sda_oe;
    logic cs;
    logic sk;
    logic di;
  } sems_core_s;

  localparam sems_core_s CORE_RST = '0;

  // Address width from the size strap
  function automatic logic [3:0] addr_width(input logic [1:0] strap);
    case (strap)
      2'h0: addr_width = AW_SMALL;
      2'h1: addr_width = AW_MID;
      2'h2: addr_width = AW_LARGE;
      default: addr_width = 4'h0;
    endcase
  endfunction : addr_width

  // Commands carrying a data byte in either direction
  function automatic logic has_data(input sems_cmd_e cmd);
    has_data = (cmd == CMD_READ) || (cmd == CMD_WRITE) || (cmd == CMD_WRITE_ALL_CMD);
  endfunction : has_data

  // Commands answered with ready/busy
  function automatic logic has_status(input sems_cmd_e cmd);
    has_status = (cmd == CMD_ERASE) || (cmd == CMD_ERASE_ALL_CMD) || (cmd == CMD_WRITE) ||
                 (cmd == CMD_WRITE_ALL_CMD);
  endfunction : has_status

  // Clocks per three-wire frame
  function automatic logic [4:0] mw_clocks(input sems_cmd_e cmd, input logic [3:0] aw);
    mw_clocks = 5'(MW_HEAD_BITS) + 5'(aw) + (has_data(cmd) ? 5'(MW_DATA_BITS) : 5'h00);
  endfunction : mw_clocks

  // Left-aligned three-wire frame: start, opcode, address, data
  function automatic logic [MW_FRAME_W-1:0] mw_frame(input sems_cmd_e cmd,
                                                     input logic [3:0] aw,
                                                     input logic [10:0] addr,
                                                     input logic [7:0] data);
    logic [1:0] op;
    logic [10:0] fld;
    logic [3:0] sh;
    sh = 4'(MW_ADDR_MAX) - aw;
    fld = addr << sh;
    op = OP_MISC;
    case (cmd)
      CMD_READ: op = OP_READ;
      CMD_WRITE: op = OP_WRITE;
      CMD_ERASE: op = OP_ERASE;
      CMD_ERASE_ALL_CMD: fld = {SUB_ERASE_ALL_CMD, 9'h000};
      CMD_PROGRAM_DISABLE_CMD: fld = {SUB_PROGRAM_DISABLE_CMD, 9'h000};
      CMD_PROGRAM_ENABLE_CMD: fld = {SUB_PROGRAM_ENABLE_CMD, 9'h000};
      CMD_WRITE_ALL_CMD: fld = {SUB_WRITE_ALL_CMD, 9'h000};
      default: op = OP_MISC;
    endcase
    mw_frame = {1'b1, op, fld, 8'h00} | (MW_FRAME_W'(data) << sh);
  endfunction : mw_frame

endpackage : sems_pkg

/* logic/sems_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module sems_pin_sync #(
  parameter int WIDTH = 3
) (
  input logic clk,
  input logic srst,
  input logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sems_sync_s;

  sems_sync_s r;
  sems_sync_s n;

  // Shift chain; output follows only when stages two and three agree
  always_comb begin
    n = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= {4 * WIDTH{sems_pkg::SYNC_RST_LEVEL}};
    end else begin
      r <= n;
    end
  end

  assign dout = r.q;

endmodule : sems_pin_sync

/* logic/sems_top.sv */
// Serial EEPROM master sequencer for two-wire and three-wire memories
module sems_top #(
  parameter int TIMEOUT_CYCLES = sems_pkg::TIMEOUT_CYCLES,
  parameter int QUARTER_CYCLES = sems_pkg::QUARTER_CYCLES
) (
  input logic clk,
  input logic srst,
  input logic cmd_start,
  input sems_pkg::sems_cmd_e cmd_code,
  input logic three_wire_mode,
  input logic [1:0] size_strap,
  input logic [15:0] target_location_field,
  input logic [7:0] write_data,
  input logic [7:0] load_count,
  input logic timeout_clear,
  output logic busy,
  output logic cmd_done,
  output logic ack_timeout_flag,
  output logic [7:0] read_data,
  output logic read_valid,
  input logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic mw_cs,
  output logic mw_sk,
  output logic mw_di,
  input logic mw_do
);

  localparam int TW = sems_pkg::TMO_W;
  localparam int QW = sems_pkg::QTR_W;
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);
  localparam logic [QW-1:0] QTR_LAST = QW'(QUARTER_CYCLES - 1);

  // Refuse counts the counters cannot hold
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << TW)) begin : g_bad_tmo
    $error("TIMEOUT_CYCLES out of range");
  end
  if (QUARTER_CYCLES < 2 || QUARTER_CYCLES >= (1 << QW)) begin : g_bad_qtr
    $error("QUARTER_CYCLES out of range");
  end

  sems_pkg::sems_core_s r;
  sems_pkg::sems_core_s n;
  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic do_s;
  logic qend;
  logic stretch;
  logic tmo_out;
  logic [2:0] sel_bits;

  // Pin inputs cross into the clock domain
  sems_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din({scl_in, sda_in, mw_do}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign do_s = pins_s[0];
  assign qend = r.tick == QTR_LAST;
  // Clock released by us but still held low by the memory
  assign stretch = !r.scl_oe && !scl_s && (r.state inside {sems_pkg::ST_I_START,
                   sems_pkg::ST_I_BYTE, sems_pkg::ST_I_STOP});
  assign tmo_out = r.tmo >= TMO_LAST;
  // Select bits follow address 10..8 only with one address byte
  assign sel_bits = r.two_byte ? sems_pkg::SEL_LOW : r.addr[10:8];

  // Next-state logic of the whole sequencer
  always_comb begin
    logic adv;
    logic set_flag;
    logic rx;
    adv = 1'b0;
    set_flag = 1'b0;
    rx = r.step == sems_pkg::STEP_RX;
    n = r;
    n.done = 1'b0;
    n.rvalid = 1'b0;
    n.od_level = 1'b0;
    // Quarter-bit timing with clock-stretch watch
    if (r.state != sems_pkg::ST_IDLE && r.state != sems_pkg::ST_FINISH) begin
      if (!qend) begin
        n.tick = r.tick + 1'b1;
      end else if (stretch) begin
        n.hold = r.hold + 1'b1;
        if (r.hold >= TMO_LAST) begin
          set_flag = 1'b1;
          n.state = sems_pkg::ST_FINISH;
        end
      end else begin
        n.tick = '0;
        n.hold = '0;
        n.q = r.q + 2'h1;
        adv = 1'b1;
      end
    end
    // Completion wait timer for polling and ready/busy
    if ((r.step == sems_pkg::STEP_POLL && r.state != sems_pkg::ST_FINISH) ||
        r.state == sems_pkg::ST_M_STATUS) begin
      n.tmo = r.tmo + 1'b1;
    end
    case (r.state)
      sems_pkg::ST_IDLE: begin
        if (cmd_start) begin
          n.busy = 1'b1;
          n.cmd = cmd_code;
          n.addr = target_location_field;
          n.wdata = write_data;
          n.aw = sems_pkg::addr_width(size_strap);
          n.two_byte = size_strap[0];
          n.tick = '0;
          n.q = 2'h0;
          n.hold = '0;
          n.tmo = '0;
          n.step = sems_pkg::STEP_CTRL_W;
          n.state = sems_pkg::ST_FINISH;
          if (three_wire_mode) begin
            if (size_strap != sems_pkg::STRAP_RESERVED && cmd_code != sems_pkg::CMD_LOAD) begin
              n.frame = sems_pkg::mw_frame(cmd_code, sems_pkg::addr_width(size_strap),
                                           target_location_field[10:0], write_data);
              n.mw_left = sems_pkg::mw_clocks(cmd_code, sems_pkg::addr_width(size_strap));
              n.cs = 1'b1;
              n.state = sems_pkg::ST_M_SHIFT;
            end
          end else if (cmd_code inside {sems_pkg::CMD_READ, sems_pkg::CMD_WRITE,
                                        sems_pkg::CMD_LOAD}) begin
            // Loader fetch is one sequential read of load_count bytes, or of one byte when load_count is zero
            n.remain = (cmd_code == sems_pkg::CMD_LOAD && load_count != 8'h00) ?
                       load_count : 8'h01;
            n.state = sems_pkg::ST_I_START;
          end
        end
      end
      sems_pkg::ST_I_START: begin
        if (adv) begin
          case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.bitn = 4'h0;
              n.state = sems_pkg::ST_I_BYTE;
              case (r.step)
                sems_pkg::STEP_FIN: n.state = sems_pkg::ST_I_STOP;
                sems_pkg::STEP_CTRL_R: n.shreg = {sems_pkg::CTRL_CODE, sel_bits,
                                                  sems_pkg::DIR_READ};
                sems_pkg::STEP_POLL: n.shreg = {sems_pkg::CTRL_CODE, sems_pkg::SEL_LOW,
                                                sems_pkg::DIR_WRITE};
                default: n.shreg = {sems_pkg::CTRL_CODE, sel_bits, sems_pkg::DIR_WRITE};
              endcase
            end
          endcase
        end
      end
      sems_pkg::ST_I_BYTE: begin
        if (adv) begin
          case (r.q)
            2'h0: begin
              if (r.bitn < 4'(sems_pkg::BYTE_BITS)) begin
                n.sda_oe = rx ? 1'b0 : !r.shreg[7];
              end else begin
                n.sda_oe = rx && (r.remain > 8'h01);
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.scl_oe = 1'b0;
            default: begin
              n.scl_oe = 1'b1;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn < 4'(sems_pkg::BYTE_BITS)) begin
                n.shreg = {r.shreg[6:0], sda_s};
              end else if (rx) begin
                n.rdata = r.shreg;
                n.rvalid = 1'b1;
                n.remain = r.remain - 8'h01;
                n.bitn = 4'h0;
                if (r.remain <= 8'h01) begin
                  n.state = sems_pkg::ST_I_STOP;
                end
              end else if (sda_s) begin
                n.step = sems_pkg::STEP_FIN;
                n.state = sems_pkg::ST_I_STOP;
                if (r.step == sems_pkg::STEP_POLL) begin
                  if (tmo_out) begin
                    set_flag = 1'b1;
                  end else begin
                    n.step = sems_pkg::STEP_POLL;
                    n.state = sems_pkg::ST_I_START;
                  end
                end else begin
                  set_flag = 1'b1;
                end
              end else begin
                n.bitn = 4'h0;
                case (r.step)
                  sems_pkg::STEP_CTRL_W: begin
                    n.step = r.two_byte ? sems_pkg::STEP_ADDR_HI : sems_pkg::STEP_ADDR_LO;
                    n.shreg = r.two_byte ? r.addr[15:8] : r.addr[7:0];
                  end
                  sems_pkg::STEP_ADDR_HI: begin
                    n.step = sems_pkg::STEP_ADDR_LO;
                    n.shreg = r.addr[7:0];
                  end
                  sems_pkg::STEP_ADDR_LO: begin
                    if (r.cmd == sems_pkg::CMD_WRITE) begin
                      n.step = sems_pkg::STEP_DATA;
                      n.shreg = r.wdata;
                    end else begin
                      n.step = sems_pkg::STEP_CTRL_R;
                      n.state = sems_pkg::ST_I_START;
                    end
                  end
                  sems_pkg::STEP_CTRL_R: n.step = sems_pkg::STEP_RX;
                  sems_pkg::STEP_DATA: n.state = sems_pkg::ST_I_STOP;
                  default: begin
                    n.step = sems_pkg::STEP_FIN;
                    n.state = sems_pkg::ST_I_START;
                  end
                endcase
              end
            end
          endcase
        end
      end
      sems_pkg::ST_I_STOP: begin
        if (adv) begin
          case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default: begin
              if (r.step == sems_pkg::STEP_DATA) begin
                n.step = sems_pkg::STEP_POLL;
                n.tmo = '0;
                n.state = sems_pkg::ST_I_START;
              end else begin
                n.state = sems_pkg::ST_FINISH;
              end
            end
          endcase
        end
      end
      sems_pkg::ST_M_SHIFT: begin
        if (adv) begin
          case (r.q)
            2'h0: n.di = r.frame[sems_pkg::MW_FRAME_W-1];
            2'h1: n.sk = 1'b1;
            2'h2: n.sk = 1'b1;
            default: begin
              n.sk = 1'b0;
              n.rdata = {r.rdata[6:0], do_s};
              n.frame = r.frame << 1;
              n.mw_left = r.mw_left - 5'h01;
              if (r.mw_left <= 5'h01) begin
                n.di = 1'b0;
                n.cs = 1'b0;
                n.rvalid = r.cmd == sems_pkg::CMD_READ;
                n.state = sems_pkg::has_status(r.cmd) ? sems_pkg::ST_M_GAP :
                          sems_pkg::ST_FINISH;
              end
            end
          endcase
        end
      end
      sems_pkg::ST_M_GAP: begin
        if (adv) begin
          n.cs = 1'b1;
          n.tmo = '0;
          n.state = sems_pkg::ST_M_STATUS;
        end
      end
      sems_pkg::ST_M_STATUS: begin
        // Ignore the line until the re-selected level has crossed the synchroniser
        if (adv && do_s && r.tmo >= TW'(sems_pkg::SYNC_LAT_CYCLES)) begin
          n.cs = 1'b0;
          n.state = sems_pkg::ST_FINISH;
        end else if (adv && tmo_out) begin
          set_flag = 1'b1;
          n.cs = 1'b0;
          n.state = sems_pkg::ST_FINISH;
        end
      end
      default: begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        n.cs = 1'b0;
        n.sk = 1'b0;
        n.di = 1'b0;
        n.step = sems_pkg::STEP_CTRL_W;
        n.state = sems_pkg::ST_IDLE;
      end
    endcase
    // Sticky timeout flag; a new event beats the clear
    n.flag = set_flag || (r.flag && !timeout_clear);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= sems_pkg::CORE_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign busy = r.busy;
  assign cmd_done = r.done;
  assign ack_timeout_flag = r.flag;
  assign read_data = r.rdata;
  assign read_valid = r.rvalid;
  assign scl_out = r.od_level;
  assign sda_out = r.od_level;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
  assign mw_cs = r.cs;
  assign mw_sk = r.sk;
  assign mw_di = r.di;

endmodule : sems_top

/* tb/sems_checker.sv */
// Port-level assertions for the serial EEPROM master sequencer
module sems_checker #(
  parameter int TIMEOUT_CYCLES = 2000,
  parameter int QUARTER_CYCLES = 4
) (
  input logic clk,
  input logic srst,
  input logic cmd_start,
  input logic three_wire_mode,
  input logic [1:0] size_strap,
  input logic busy,
  input logic cmd_done,
  input logic ack_timeout_flag,
  input logic read_valid,
  input logic scl_oe,
  input logic sda_oe,
  input logic mw_cs,
  input logic mw_sk,
  input logic mw_di
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] n_sk;
  logic [15:0] run;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Link clocks in a frame and length of the current scl level
  always_ff @(posedge clk) begin
    if (srst || !mw_cs) n_sk <= 5'h00;
    else if ($rose(mw_sk)) n_sk <= n_sk + 5'h01;
    if (srst || $changed(scl_oe)) run <= 16'h0001;
    else run <= run + 16'h0001;
  end

  sequence s_take;
    cmd_start && !busy;
  endsequence
  sequence s_quiet_end;
    !mw_cs ##1 (cmd_done && !mw_cs);
  endsequence

  property p_rsvd;
    s_take ##0 (three_wire_mode && size_strap == 2'h3) |=> s_quiet_end;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved strap started a frame");
  property p_clocks;
    $fell(mw_cs) |-> n_sk inside {5'h00, 5'h0a, 5'h0c, 5'h0e, 5'h12, 5'h14, 5'h16};
  endproperty
  a_clocks: assert property (p_clocks) else $error("bad clock count in frame");
  property p_sk_in_cs;
    mw_sk |-> mw_cs;
  endproperty
  a_sk_in_cs: assert property (p_sk_in_cs) else $error("link clock outside select");
  property p_di_hold;
    mw_sk && $past(mw_sk) |-> $stable(mw_di);
  endproperty
  a_di_hold: assert property (p_di_hold) else $error("data moved while clock high");
  property p_lo_time;
    $rose(scl_oe) && busy |-> run >= 16'(2 * QUARTER_CYCLES);
  endproperty
  a_lo_time: assert property (p_lo_time) else $error("scl high phase too short");
  property p_hi_time;
    $fell(scl_oe) && busy |-> run >= 16'(QUARTER_CYCLES);
  endproperty
  a_hi_time: assert property (p_hi_time) else $error("scl low phase too short");
  property p_one_mode;
    mw_cs |-> !scl_oe && !sda_oe;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("both links active");
  property p_flag_cause;
    $rose(ack_timeout_flag) |-> $past(busy);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set while idle");
  property p_take;
    s_take |=> busy;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_done_pulse;
    cmd_done |-> !busy ##1 !cmd_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
  property p_rv_busy;
    read_valid |-> busy;
  endproperty
  a_rv_busy: assert property (p_rv_busy) else $error("byte delivered while idle");
endmodule : sems_checker

bind sems_top sems_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .QUARTER_CYCLES(QUARTER_CYCLES))
  u_chk (.clk(clk), .srst(srst), .cmd_start(cmd_start), .three_wire_mode(three_wire_mode),
  .size_strap(size_strap), .busy(busy), .cmd_done(cmd_done),
  .ack_timeout_flag(ack_timeout_flag), .read_valid(read_valid), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .mw_cs(mw_cs), .mw_sk(mw_sk), .mw_di(mw_di));

/* tb/sems_mem_model.sv */
// Behavioural serial EEPROM answering on both link kinds
module sems_mem_model (
  input logic clk,
  input logic scl_oe,
  input logic sda_oe,
  output logic scl,
  output logic sda,
  input logic two_b,
  input logic [1:0] strap,
  input logic ack_off,
  input logic stuck,
  input logic hold_scl,
  input logic mw_cs,
  input logic mw_sk,
  input logic mw_di,
  output logic mw_do,
  output logic [7:0] last_ctrl,
  output int n_poll,
  output logic [4:0] last_n,
  output logic [21:0] last_f,
  output int n_frames
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ps = 1, pd = 1, m_low = 0, rd = 0, go = 0, wr = 0, psk = 0, pcs = 0, stat = 0;
  logic [3:0] bitc = 4'hf;
  logic [7:0] sh, dat, ptr = 8'h00, md;
  logic [2:0] nb = 3'h0;
  logic [4:0] n = 5'h00;
  logic [21:0] f;
  int wbusy = 0, bz = 0;
  assign scl = !(scl_oe || hold_scl);
  assign sda = !(sda_oe || m_low);
  initial begin
    n_poll = 0;
    n_frames = 0;
    mw_do = 1'b0;
  end
  // Two-wire side on the falling edge, clear of the design's launch edge
  always @(negedge clk) begin
    if (scl && ps && pd && !sda) begin
      bitc = 4'h0; nb = 3'h0; rd = 0; m_low = 0;
    end else if (scl && ps && !pd && sda) begin
      if (wr) wbusy = stuck ? 1 << 30 : 3;
      wr = 0; bitc = 4'hf;
    end else if (bitc < 4'hf && !ps && scl) begin
      if (bitc < 4'h8) sh = {sh[6:0], sda};
      else begin
        if (rd && nb > 3'h0) begin go = !sda; ptr++; dat = ptr ^ 8'h5a; end
        nb++;
      end
      bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
    end else if (bitc < 4'hf && ps && !scl) begin
      if (bitc == 4'h8 && rd && nb > 3'h0) m_low = 0;
      else if (bitc == 4'h8) begin
        m_low = !ack_off;
        if (nb == 3'h0) begin
          last_ctrl = sh; rd = sh[0]; dat = ptr ^ 8'h5a; go = 1;
          if (wbusy > 0 && !sh[0]) begin m_low = 0; wbusy--; n_poll++; end
        end else if (nb == {2'h0, two_b} + 3'h1) ptr = sh;
        else if (nb == {2'h0, two_b} + 3'h2) wr = 1;
      end else m_low = rd && go && nb > 3'h0 && !dat[7 - bitc];
    end
    ps = scl; pd = sda;
  end
  // Three-wire side on the falling edge: frames, read bits, ready/busy
  always @(negedge clk) begin
    if (!mw_cs) begin
      if (pcs && n > 5'h00) begin
        last_n = n; last_f = f; n_frames++; stat = 1; bz = stuck ? 1 << 30 : 20;
      end else if (pcs) stat = 0;
      n = 5'h00; f = '0; mw_do = !mw_do;
    end else begin
      if (!psk && mw_sk) begin
        f = {f[20:0], mw_di}; n++;
        if (n == 10 + 2 * strap) md = f[7:0] ^ 8'h5a;
      end
      if (n > 10 + 2 * strap) mw_do = (n <= 18 + 2 * strap) ? md[18 + 2 * strap - n] : 1'b0;
      else if (n == 5'h00 && stat) begin bz--; mw_do = (bz <= 0); end
      else mw_do = !mw_do;
    end
    psk = mw_sk; pcs = mw_cs;
  end
endmodule : sems_mem_model

/* tb/test_sems_top.sv */
// Self-checking bench of the sequencer against a memory model
module test_sems_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, cmd_start, tw, tclr, busy, done, flag, rvalid;
  logic scl_oe, sda_oe, scl, sda, cs, sk, di, mdo, ack_off, stuck, hold_scl;
  logic [1:0] so;
  sems_pkg::sems_cmd_e cmd_code;
  logic [1:0] strap;
  logic [15:0] addr, a;
  logic [7:0] wdata, lcnt, rdata, d, last_ctrl;
  logic [4:0] last_n;
  logic [21:0] last_f, h;
  int n_fail = 0, n_checks = 0, n_poll, n_frames, nf, cyc = 0, aw, dl;
  logic [7:0] rq[$];

  sems_top #(.TIMEOUT_CYCLES(2000), .QUARTER_CYCLES(4)) DUT (.clk(clk), .srst(srst),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .three_wire_mode(tw), .size_strap(strap),
    .target_location_field(addr), .write_data(wdata), .load_count(lcnt), .timeout_clear(tclr),
    .busy(busy), .cmd_done(done), .ack_timeout_flag(flag), .read_data(rdata),
    .read_valid(rvalid), .scl_in(scl), .scl_out(so[1]), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(so[0]), .sda_oe(sda_oe), .mw_cs(cs), .mw_sk(sk), .mw_di(di), .mw_do(mdo));
  sems_mem_model u_mem (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .two_b(strap[0]), .strap(strap), .ack_off(ack_off), .stuck(stuck), .hold_scl(hold_scl),
    .mw_cs(cs), .mw_sk(sk), .mw_di(di), .mw_do(mdo), .last_ctrl(last_ctrl), .n_poll(n_poll),
    .last_n(last_n), .last_f(last_f), .n_frames(n_frames));

  // Expected three-wire start bit, opcode and address field
  function automatic logic [21:0] hdr(input int c, input int aw, input logic [10:0] a);
    logic [1:0] op;
    logic [21:0] m;
    m = a & ((22'h1 << aw) - 22'h1);
    op = 2'h0;
    case (c)
      0: op = 2'h2;
      1: op = 2'h1;
      2: op = 2'h3;
      3: m = 22'h2 << (aw - 2);
      5: m = 22'h3 << (aw - 2);
      6: m = 22'h1 << (aw - 2);
      default: m = 22'h0;
    endcase
    hdr = ((22'h4 | op) << aw) | m;
  endfunction : hdr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // One command from request to done pulse
  task automatic run(input int c, input logic t, input logic [1:0] s, input logic [15:0] ad,
                     input logic [7:0] wd, input logic [7:0] lc);
    int k;
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_code <= sems_pkg::sems_cmd_e'(c);
    tw <= t;
    strap <= s;
    addr <= ad;
    wdata <= wd;
    lcnt <= lc;
    @(posedge clk);
    cmd_start <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) chk(0, 1);
  endtask : run

  task automatic clr;
    @(posedge clk);
    tclr <= 1'b1;
    @(posedge clk);
    tclr <= 1'b0;
    @(negedge clk);
    chk(flag, 0);
  endtask : clr

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // Byte collection and run limit
  always @(posedge clk) begin
    if (rvalid === 1'b1) rq.push_back(rdata);
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    srst = 1; cmd_start = 0; cmd_code = sems_pkg::CMD_READ; tw = 0; strap = 2'h0;
    addr = 16'h0000; wdata = 8'h00; lcnt = 8'h00; tclr = 0; ack_off = 0; stuck = 0; hold_scl = 0;
    void'($urandom(32'h37259afb));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // Write with three busy polls
    a = $urandom;
    d = $urandom;
    run(1, 0, 2'h0, a, d, 8'h00);
    chk(flag, 0);
    chk(n_poll, 3);
    chk(last_ctrl, 8'ha0);
    chk(so, 2'h0);
    // Single and sequential reads, both address sizes
    for (int s = 0; s < 2; s++) begin
      a = $urandom;
      rq.delete();
      run(0, 0, 2'(s), a, 8'h00, 8'h00);
      chk(rq.size(), 1);
      chk(rdata, a[7:0] ^ 8'h5a);
      chk(last_ctrl, s ? 8'ha1 : {4'ha, a[10:8], 1'b1});
      rq.delete();
      run(7, 0, 2'(s), a, 8'h00, 8'h03);
      chk(rq.size(), 3);
      for (int k = 0; k < 3; k++) chk(rq[k], 8'(a[7:0] + k) ^ 8'h5a);
    end
    // Refused byte aborts with the flag
    ack_off <= 1'b1;
    run(0, 0, 2'h0, a, 8'h00, 8'h00);
    chk(flag, 1);
    ack_off <= 1'b0;
    clr();
    // Polling that never succeeds
    stuck <= 1'b1;
    run(1, 0, 2'h1, a, d, 8'h00);
    chk(flag, 1);
    stuck <= 1'b0;
    clr();
    // Clock held low by the memory aborts with the flag
    hold_scl <= 1'b1;
    run(0, 0, 2'h0, a, 8'h00, 8'h00);
    chk(flag, 1);
    hold_scl <= 1'b0;
    clr();
    // Every three-wire command at every width
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 7; c++) begin
        a = $urandom;
        d = $urandom;
        run(c, 1, 2'(s), a, d, 8'h00);
        aw = 7 + 2 * s;
        h = hdr(c, aw, a[10:0]);
        dl = (c == 0 || c == 1 || c == 6) ? 8 : 0;
        chk(last_n, 3 + aw + dl);
        chk(last_f >> dl, h);
        if (c == 1 || c == 6) chk(last_f[7:0], d);
        if (c == 0) chk(rdata, h[7:0] ^ 8'h5a);
        chk(flag, 0);
      end
    end
    // Reserved width starts no frame
    nf = n_frames;
    run(0, 1, 2'h3, a, d, 8'h00);
    chk(n_frames, nf);
    // Erase with the memory never ready
    stuck <= 1'b1;
    run(2, 1, 2'h1, a, d, 8'h00);
    chk(flag, 1);
    results();
  end
endmodule : test_sems_top
